// ---- rtl/edsb_pkg.sv ----
// Constants for the exception detail status bank.
// Assumes one 40 MHz clock domain shared with the attribute reader.
package edsb_pkg;

  // Detail group selected on a read
  typedef enum logic [2:0] {
    EDSB_GRP_ALARM_COMMON,
    EDSB_GRP_ALARM_DEVICE,
    EDSB_GRP_ALARM_MAKER,
    EDSB_GRP_WARN_COMMON,
    EDSB_GRP_WARN_DEVICE,
    EDSB_GRP_WARN_MAKER
  } edsb_group_t;

  // Size bytes per group
  localparam logic [7:0] EDSB_SIZE_COMMON = 8'h02;
  localparam logic [7:0] EDSB_SIZE_DEVICE = 8'h05;
  localparam logic [7:0] EDSB_SIZE_MAKER  = 8'h01;

  // Read index: 0 is the size byte, 1..n are detail bytes 0..n-1
  localparam logic [2:0] EDSB_IDX_SIZE    = 3'h0;
  localparam logic [2:0] EDSB_IDX_BYTE0   = 3'h1;
  localparam logic [2:0] EDSB_IDX_BYTE1   = 3'h2;
  localparam logic [2:0] EDSB_IDX_BYTE2   = 3'h3;
  localparam logic [2:0] EDSB_IDX_BYTE3   = 3'h4;
  localparam logic [2:0] EDSB_IDX_BYTE4   = 3'h5;

  // Common group, byte 0
  localparam int EDSB_BIT_RAM     = 4;
  localparam int EDSB_BIT_NVS     = 3;
  localparam int EDSB_BIT_FLASH   = 2;
  localparam int EDSB_BIT_DIAG    = 0;
  // Device group, byte 0
  localparam int EDSB_BIT_PV_CTRL = 3;
  localparam int EDSB_BIT_PV_HIGH = 2;
  localparam int EDSB_BIT_PV_LOW  = 1;
  localparam int EDSB_BIT_INV_S1  = 0;
  // Device group, byte 1
  localparam int EDSB_BIT_TEMP_LO = 7;
  localparam int EDSB_BIT_INV_S5  = 6;
  localparam int EDSB_BIT_FLOW_HI = 5;
  localparam int EDSB_BIT_FLOW_LO = 4;
  localparam int EDSB_BIT_INV_S4  = 3;
  // Device group, byte 2
  localparam int EDSB_BIT_TEMP_HI = 0;
  // Maker group, byte 0
  localparam int EDSB_BIT_ACT_HI  = 1;
  localparam int EDSB_BIT_ACT_LO  = 0;

  // Exception status byte
  localparam int         EDSB_STAT_ALARM_BASE = 0;
  localparam int         EDSB_STAT_WARN_BASE  = 4;
  localparam logic [7:0] EDSB_STAT_FIXED      = 8'h80;

  // Synchroniser vector layout
  localparam int EDSB_SRC_W      = 26;
  localparam int EDSB_SRC_A_COM  = 0;
  localparam int EDSB_SRC_A_DEV  = 4;
  localparam int EDSB_SRC_A_MKR  = 11;
  localparam int EDSB_SRC_W_DIAG = 13;
  localparam int EDSB_SRC_W_DEV  = 14;
  localparam int EDSB_SRC_W_MKR  = 21;
  localparam int EDSB_SRC_VALID  = 23;

  // Reset values and latencies in clock cycles
  localparam logic [7:0] EDSB_RESET_BYTE   = 8'h00;
  localparam logic [7:0] EDSB_RESET_STATUS = 8'h80;
  localparam int         EDSB_PIN_TO_DETAIL = 3;
  localparam int         EDSB_PIN_TO_STATUS = 4;
  localparam logic [2:0] EDSB_WARM_MAX      = 3'h5;

endpackage

// ---- rtl/edsb_sync.sv ----
// Two-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level with no relation to its neighbours.
`timescale 1ns/10ps
module edsb_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ---- rtl/edsb_bank.sv ----
// Exception detail status bank: alarm and warning detail bytes plus summary.
// Assumes fault and valid inputs are asynchronous levels from the supervisor,
// and the attribute reader sits on the same clock.
//
// What this block does
// - Common alarm group reports size two
// - Common alarm byte0 memory and diagnostic bits
// - Device alarm group reports size five
// - Device alarm byte0 controller and PV limits
// - Device alarm flow, temperature bits; bytes3-4 zero
// - Maker alarm one byte, actuator limits
// - Common warning two bytes, diagnostic bit0
// - Device warning flags invalid sensor readings
// - Device warning reuses alarm limit positions
// - Maker warning one byte, actuator limits
// - Invalid bit is inverse of valid
// - Invalid positions always zero in alarms
// - Summary bit ORs its detail group
// - Valid flag high means reading valid
`timescale 1ns/10ps
module edsb_bank
  import edsb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Alarm sources
  input  wire logic        ram_fault,
  input  wire logic        nonvolatile_store_fault,
  input  wire logic        flash_fault,
  input  wire logic        diag_fault,
  input  wire logic        alm_pv_ctrl,
  input  wire logic        alm_pv_high,
  input  wire logic        alm_pv_low,
  input  wire logic        alm_temp_low,
  input  wire logic        alm_flow_high,
  input  wire logic        alm_flow_low,
  input  wire logic        alm_temp_high,
  input  wire logic        alm_act_high,
  input  wire logic        alm_act_low,
  // Warning sources
  input  wire logic        diag_warn,
  input  wire logic        wrn_pv_ctrl,
  input  wire logic        wrn_pv_high,
  input  wire logic        wrn_pv_low,
  input  wire logic        wrn_temp_low,
  input  wire logic        wrn_flow_high,
  input  wire logic        wrn_flow_low,
  input  wire logic        wrn_temp_high,
  input  wire logic        wrn_act_high,
  input  wire logic        wrn_act_low,
  input  wire logic        s1_reading_valid,
  input  wire logic        s4_reading_valid,
  input  wire logic        s5_reading_valid,
  // Attribute read port
  input  wire logic        rd_req,
  input  wire edsb_group_t rd_group,
  input  wire logic [2:0]  rd_index,
  output logic             rd_ack,
  output logic             rd_err,
  output logic [7:0]       rd_data,
  // Exception status summary
  output logic [7:0]       exc_status
);

  logic [EDSB_SRC_W-1:0] src_raw;
  logic [EDSB_SRC_W-1:0] src;

  assign src_raw = {s5_reading_valid, s4_reading_valid, s1_reading_valid,
                    wrn_act_high, wrn_act_low,
                    wrn_temp_high, wrn_flow_low, wrn_flow_high, wrn_temp_low,
                    wrn_pv_low, wrn_pv_high, wrn_pv_ctrl,
                    diag_warn,
                    alm_act_high, alm_act_low,
                    alm_temp_high, alm_flow_low, alm_flow_high, alm_temp_low,
                    alm_pv_low, alm_pv_high, alm_pv_ctrl,
                    diag_fault, flash_fault, nonvolatile_store_fault, ram_fault};

  edsb_sync #(
    .W (EDSB_SRC_W)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (src_raw),
    .dout   (src)
  );

  // Synchronised source names
  logic s_ram, s_nvs, s_flash, s_diag;
  logic a_ctrl, a_high, a_low, a_tlo, a_fhi, a_flo, a_thi, a_ahi, a_alo;
  logic w_diag;
  logic w_ctrl, w_high, w_low, w_tlo, w_fhi, w_flo, w_thi, w_ahi, w_alo;
  logic v_s1, v_s4, v_s5;

  assign s_ram   = src[EDSB_SRC_A_COM];
  assign s_nvs   = src[EDSB_SRC_A_COM+1];
  assign s_flash = src[EDSB_SRC_A_COM+2];
  assign s_diag  = src[EDSB_SRC_A_COM+3];
  assign a_ctrl  = src[EDSB_SRC_A_DEV];
  assign a_high  = src[EDSB_SRC_A_DEV+1];
  assign a_low   = src[EDSB_SRC_A_DEV+2];
  assign a_tlo   = src[EDSB_SRC_A_DEV+3];
  assign a_fhi   = src[EDSB_SRC_A_DEV+4];
  assign a_flo   = src[EDSB_SRC_A_DEV+5];
  assign a_thi   = src[EDSB_SRC_A_DEV+6];
  assign a_alo   = src[EDSB_SRC_A_MKR];
  assign a_ahi   = src[EDSB_SRC_A_MKR+1];
  assign w_diag  = src[EDSB_SRC_W_DIAG];
  assign w_ctrl  = src[EDSB_SRC_W_DEV];
  assign w_high  = src[EDSB_SRC_W_DEV+1];
  assign w_low   = src[EDSB_SRC_W_DEV+2];
  assign w_tlo   = src[EDSB_SRC_W_DEV+3];
  assign w_fhi   = src[EDSB_SRC_W_DEV+4];
  assign w_flo   = src[EDSB_SRC_W_DEV+5];
  assign w_thi   = src[EDSB_SRC_W_DEV+6];
  assign w_alo   = src[EDSB_SRC_W_MKR];
  assign w_ahi   = src[EDSB_SRC_W_MKR+1];
  assign v_s1    = src[EDSB_SRC_VALID];
  assign v_s4    = src[EDSB_SRC_VALID+1];
  assign v_s5    = src[EDSB_SRC_VALID+2];

  // Detail bytes; reserved bytes are constant zero and hold no flops
  logic [7:0] alarm_common_byte0;
  logic [7:0] alarm_device_byte0;
  logic [7:0] alarm_device_byte1;
  logic [7:0] alarm_device_byte2;
  logic [7:0] alarm_maker_byte0;
  logic [7:0] warning_common_byte0;
  logic [7:0] warning_device_byte0;
  logic [7:0] warning_device_byte1;
  logic [7:0] warning_device_byte2;
  logic [7:0] warning_maker_byte0;

  logic [7:0] next_alarm_common_byte0;
  logic [7:0] next_alarm_device_byte0;
  logic [7:0] next_alarm_device_byte1;
  logic [7:0] next_alarm_device_byte2;
  logic [7:0] next_alarm_maker_byte0;
  logic [7:0] next_warning_common_byte0;
  logic [7:0] next_warning_device_byte0;
  logic [7:0] next_warning_device_byte1;
  logic [7:0] next_warning_device_byte2;
  logic [7:0] next_warning_maker_byte0;

  always_comb begin
    next_alarm_common_byte0 = 8'h00;
    next_alarm_common_byte0[EDSB_BIT_RAM]   = s_ram;
    next_alarm_common_byte0[EDSB_BIT_NVS]   = s_nvs;
    next_alarm_common_byte0[EDSB_BIT_FLASH] = s_flash;
    next_alarm_common_byte0[EDSB_BIT_DIAG]  = s_diag;

    // Invalid positions left at zero in the alarm copy
    next_alarm_device_byte0 = 8'h00;
    next_alarm_device_byte0[EDSB_BIT_PV_CTRL] = a_ctrl;
    next_alarm_device_byte0[EDSB_BIT_PV_HIGH] = a_high;
    next_alarm_device_byte0[EDSB_BIT_PV_LOW]  = a_low;
    next_alarm_device_byte1 = 8'h00;
    next_alarm_device_byte1[EDSB_BIT_TEMP_LO] = a_tlo;
    next_alarm_device_byte1[EDSB_BIT_FLOW_HI] = a_fhi;
    next_alarm_device_byte1[EDSB_BIT_FLOW_LO] = a_flo;
    next_alarm_device_byte2 = 8'h00;
    next_alarm_device_byte2[EDSB_BIT_TEMP_HI] = a_thi;

    next_alarm_maker_byte0 = 8'h00;
    next_alarm_maker_byte0[EDSB_BIT_ACT_HI] = a_ahi;
    next_alarm_maker_byte0[EDSB_BIT_ACT_LO] = a_alo;

    next_warning_common_byte0 = 8'h00;
    next_warning_common_byte0[EDSB_BIT_DIAG] = w_diag;

    next_warning_device_byte0 = 8'h00;
    next_warning_device_byte0[EDSB_BIT_PV_CTRL] = w_ctrl;
    next_warning_device_byte0[EDSB_BIT_PV_HIGH] = w_high;
    next_warning_device_byte0[EDSB_BIT_PV_LOW]  = w_low;
    next_warning_device_byte0[EDSB_BIT_INV_S1]  = ~v_s1;
    next_warning_device_byte1 = 8'h00;
    next_warning_device_byte1[EDSB_BIT_TEMP_LO] = w_tlo;
    next_warning_device_byte1[EDSB_BIT_INV_S5]  = ~v_s5;
    next_warning_device_byte1[EDSB_BIT_FLOW_HI] = w_fhi;
    next_warning_device_byte1[EDSB_BIT_FLOW_LO] = w_flo;
    next_warning_device_byte1[EDSB_BIT_INV_S4]  = ~v_s4;
    next_warning_device_byte2 = 8'h00;
    next_warning_device_byte2[EDSB_BIT_TEMP_HI] = w_thi;

    next_warning_maker_byte0 = 8'h00;
    next_warning_maker_byte0[EDSB_BIT_ACT_HI] = w_ahi;
    next_warning_maker_byte0[EDSB_BIT_ACT_LO] = w_alo;
  end

  // Detail bytes track their sources every cycle, no clear needed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alarm_common_byte0   <= EDSB_RESET_BYTE;
      alarm_device_byte0   <= EDSB_RESET_BYTE;
      alarm_device_byte1   <= EDSB_RESET_BYTE;
      alarm_device_byte2   <= EDSB_RESET_BYTE;
      alarm_maker_byte0    <= EDSB_RESET_BYTE;
      warning_common_byte0 <= EDSB_RESET_BYTE;
      warning_device_byte0 <= EDSB_RESET_BYTE;
      warning_device_byte1 <= EDSB_RESET_BYTE;
      warning_device_byte2 <= EDSB_RESET_BYTE;
      warning_maker_byte0  <= EDSB_RESET_BYTE;
    end else begin
      alarm_common_byte0   <= next_alarm_common_byte0;
      alarm_device_byte0   <= next_alarm_device_byte0;
      alarm_device_byte1   <= next_alarm_device_byte1;
      alarm_device_byte2   <= next_alarm_device_byte2;
      alarm_maker_byte0    <= next_alarm_maker_byte0;
      warning_common_byte0 <= next_warning_common_byte0;
      warning_device_byte0 <= next_warning_device_byte0;
      warning_device_byte1 <= next_warning_device_byte1;
      warning_device_byte2 <= next_warning_device_byte2;
      warning_maker_byte0  <= next_warning_maker_byte0;
    end
  end

  // Summary byte
  logic [7:0] next_exc_status;

  always_comb begin
    next_exc_status = EDSB_STAT_FIXED;
    next_exc_status[EDSB_STAT_ALARM_BASE]   = |alarm_common_byte0;
    next_exc_status[EDSB_STAT_ALARM_BASE+1] =
      |{alarm_device_byte0, alarm_device_byte1, alarm_device_byte2};
    next_exc_status[EDSB_STAT_ALARM_BASE+2] = |alarm_maker_byte0;
    next_exc_status[EDSB_STAT_WARN_BASE]    = |warning_common_byte0;
    next_exc_status[EDSB_STAT_WARN_BASE+1]  =
      |{warning_device_byte0, warning_device_byte1, warning_device_byte2};
    next_exc_status[EDSB_STAT_WARN_BASE+2]  = |warning_maker_byte0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exc_status <= EDSB_RESET_STATUS;
    end else begin
      exc_status <= next_exc_status;
    end
  end

  // Attribute read decode
  logic [7:0] next_rd_data;
  logic       next_rd_err;

  always_comb begin
    next_rd_data = 8'h00;
    next_rd_err  = 1'b0;
    unique case (rd_group)
      EDSB_GRP_ALARM_COMMON, EDSB_GRP_WARN_COMMON: begin
        if (rd_index == EDSB_IDX_SIZE) begin
          next_rd_data = EDSB_SIZE_COMMON;
        end else if (rd_index == EDSB_IDX_BYTE0) begin
          next_rd_data = (rd_group == EDSB_GRP_ALARM_COMMON) ?
                         alarm_common_byte0 : warning_common_byte0;
        end else if (rd_index != EDSB_IDX_BYTE1) begin
          next_rd_err = 1'b1;
        end
      end
      EDSB_GRP_ALARM_DEVICE, EDSB_GRP_WARN_DEVICE: begin
        if (rd_index == EDSB_IDX_SIZE) begin
          next_rd_data = EDSB_SIZE_DEVICE;
        end else if (rd_index == EDSB_IDX_BYTE0) begin
          next_rd_data = (rd_group == EDSB_GRP_ALARM_DEVICE) ?
                         alarm_device_byte0 : warning_device_byte0;
        end else if (rd_index == EDSB_IDX_BYTE1) begin
          next_rd_data = (rd_group == EDSB_GRP_ALARM_DEVICE) ?
                         alarm_device_byte1 : warning_device_byte1;
        end else if (rd_index == EDSB_IDX_BYTE2) begin
          next_rd_data = (rd_group == EDSB_GRP_ALARM_DEVICE) ?
                         alarm_device_byte2 : warning_device_byte2;
        end else if (rd_index > EDSB_IDX_BYTE4) begin
          next_rd_err = 1'b1; // Bytes 3 and 4 read as zero
        end
      end
      EDSB_GRP_ALARM_MAKER, EDSB_GRP_WARN_MAKER: begin
        if (rd_index == EDSB_IDX_SIZE) begin
          next_rd_data = EDSB_SIZE_MAKER;
        end else if (rd_index == EDSB_IDX_BYTE0) begin
          next_rd_data = (rd_group == EDSB_GRP_ALARM_MAKER) ?
                         alarm_maker_byte0 : warning_maker_byte0;
        end else begin
          next_rd_err = 1'b1;
        end
      end
      default: begin
        next_rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack  <= 1'b0;
      rd_err  <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_ack  <= rd_req;
      rd_err  <= rd_req & next_rd_err;
      rd_data <= rd_req ? next_rd_data : 8'h00;
    end
  end

  // Cycles since reset release, for history-based checks
  logic [2:0] warm;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      warm <= 3'h0;
    end else if (warm != EDSB_WARM_MAX) begin
      warm <= warm + 3'h1;
    end
  end

  logic hist_ok;
  assign hist_ok = (warm == EDSB_WARM_MAX);

  sequence seq_size_read(logic [2:0] grp);
    rd_req && rd_group == edsb_group_t'(grp) && rd_index == EDSB_IDX_SIZE;
  endsequence

  sequence seq_ack_with(logic [7:0] val);
    rd_ack && !rd_err && rd_data == val;
  endsequence

  AST_COMMON_SIZE: assert property (@(posedge clock) disable iff (!arst_n)
    seq_size_read(3'h0) |=> seq_ack_with(8'h02))
    else $error("common alarm size is not two");

  AST_COMMON_MAP: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> alarm_common_byte0 == {3'b000, $past(ram_fault, 3),
      $past(nonvolatile_store_fault, 3), $past(flash_fault, 3), 1'b0,
      $past(diag_fault, 3)})
    else $error("common alarm byte0 does not match its sources");

  AST_DEVICE_SIZE: assert property (@(posedge clock) disable iff (!arst_n)
    seq_size_read(3'h1) |=> seq_ack_with(8'h05))
    else $error("device alarm size is not five");

  AST_DEVICE_B0: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> alarm_device_byte0 == {4'h0, $past(alm_pv_ctrl, 3),
      $past(alm_pv_high, 3), $past(alm_pv_low, 3), 1'b0})
    else $error("device alarm byte0 does not match its sources");

  AST_DEVICE_B12: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> alarm_device_byte1 == {$past(alm_temp_low, 3), 1'b0,
      $past(alm_flow_high, 3), $past(alm_flow_low, 3), 4'h0}
      && alarm_device_byte2 == {7'h00, $past(alm_temp_high, 3)})
    else $error("device alarm bytes 1 and 2 do not match their sources");

  AST_DEVICE_B34: assert property (@(posedge clock) disable iff (!arst_n)
    rd_req && rd_group == EDSB_GRP_ALARM_DEVICE && rd_index >= EDSB_IDX_BYTE3
      && rd_index <= EDSB_IDX_BYTE4 |=> seq_ack_with(8'h00))
    else $error("device alarm byte 3 or 4 is not zero");

  AST_MAKER_ALARM: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> alarm_maker_byte0 == {6'h00, $past(alm_act_high, 3),
      $past(alm_act_low, 3)})
    else $error("maker alarm byte does not match actuator limits");

  AST_WARN_COMMON: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> warning_common_byte0 == {7'h00, $past(diag_warn, 3)})
    else $error("common warning byte0 does not match diagnostic");

  AST_WARN_INVALID: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> warning_device_byte0[EDSB_BIT_INV_S1] == !$past(s1_reading_valid, 3)
      && warning_device_byte1[EDSB_BIT_INV_S5] == !$past(s5_reading_valid, 3)
      && warning_device_byte1[EDSB_BIT_INV_S4] == !$past(s4_reading_valid, 3))
    else $error("invalid reading bits do not track valid flags");

  AST_WARN_SAME_POS: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> warning_device_byte0[3:1] == {$past(wrn_pv_ctrl, 3),
      $past(wrn_pv_high, 3), $past(wrn_pv_low, 3)}
      && warning_device_byte1[5:4] == {$past(wrn_flow_high, 3), $past(wrn_flow_low, 3)}
      && warning_device_byte1[7] == $past(wrn_temp_low, 3)
      && warning_device_byte2 == {7'h00, $past(wrn_temp_high, 3)})
    else $error("device warning limit bits misplaced");

  AST_MAKER_WARN: assert property (@(posedge clock) disable iff (!arst_n)
    seq_size_read(3'h5) |=> seq_ack_with(8'h01))
    else $error("maker warning size is not one");

  AST_INV_FALL: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok && $fell(s1_reading_valid) |-> ##3 warning_device_byte0[EDSB_BIT_INV_S1])
    else $error("invalid bit not raised three cycles after valid fell");

  AST_ALARM_NO_INV: assert property (@(posedge clock) disable iff (!arst_n)
    alarm_device_byte0[EDSB_BIT_INV_S1] == 1'b0 && alarm_device_byte1[6] == 1'b0
      && alarm_device_byte1[3] == 1'b0)
    else $error("invalid position set in alarm group");

  AST_SUMMARY: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok |-> exc_status[7] && !exc_status[3]
      && exc_status[1] == $past(|{alarm_device_byte0, alarm_device_byte1,
                                  alarm_device_byte2}, 1)
      && exc_status[4] == $past(|warning_common_byte0, 1))
    else $error("summary bit is not the OR of its group");

  AST_VALID_HIGH: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok && s4_reading_valid [*4] |-> !warning_device_byte1[EDSB_BIT_INV_S4])
    else $error("valid sensor flagged invalid");

  AST_SELF_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
    hist_ok && $fell(ram_fault) |-> ##2 alarm_common_byte0[EDSB_BIT_RAM] ##1
      !alarm_common_byte0[EDSB_BIT_RAM])
    else $error("detail bit did not clear after source cleared");

endmodule

// ---- tb/edsb_master.sv ----
// Attribute reader model: one read at a time on the bank's read port.
// Assumes the bank answers exactly one clock after taking a request.
`timescale 1ns/10ps
module edsb_master
  import edsb_pkg::*;
(
  input  wire logic       clock,
  output logic            rd_req,
  output edsb_group_t     rd_group,
  output logic [2:0]      rd_index,
  input  wire logic       rd_ack,
  input  wire logic       rd_err,
  input  wire logic [7:0] rd_data
);
  initial begin
    rd_req   = 1'b0;
    rd_group = EDSB_GRP_ALARM_COMMON;
    rd_index = 3'h0;
  end

  // Answer cycle and the cycle after, each as {ack, err, data}
  // Taken mid-cycle, while the one-cycle answer stands
  task automatic read(input logic [2:0] g, input logic [2:0] idx,
                      output logic [9:0] ans, output logic [9:0] after);
    @(negedge clock);
    rd_req   = 1'b1;
    rd_group = edsb_group_t'(g);
    rd_index = idx;
    @(negedge clock);
    ans      = {rd_ack, rd_err, rd_data};
    rd_req   = 1'b0;
    rd_group = edsb_group_t'(~g);
    rd_index = ~idx;
    @(negedge clock);
    after    = {rd_ack, rd_err, rd_data};
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the exception detail status bank.
// Assumes the reader model answers reads; sources change at falling edges.
`timescale 1ns/10ps
module testbench;
  import edsb_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [25:0] src = 26'h3800000;
  logic        rd_req, rd_ack, rd_err;
  edsb_group_t rd_group;
  logic [2:0]  rd_index;
  logic [7:0]  rd_data, exc_status;
  int          miscompares = 0;
  int          n_checks = 0;

  always #12.5 clock = ~clock;

  edsb_bank edsb_bank_inst (.clock(clock), .arst_n(arst_n),
    .ram_fault(src[0]), .nonvolatile_store_fault(src[1]), .flash_fault(src[2]),
    .diag_fault(src[3]), .alm_pv_ctrl(src[4]), .alm_pv_high(src[5]), .alm_pv_low(src[6]),
    .alm_temp_low(src[7]), .alm_flow_high(src[8]), .alm_flow_low(src[9]),
    .alm_temp_high(src[10]), .alm_act_high(src[11]), .alm_act_low(src[12]),
    .diag_warn(src[13]), .wrn_pv_ctrl(src[14]), .wrn_pv_high(src[15]),
    .wrn_pv_low(src[16]), .wrn_temp_low(src[17]), .wrn_flow_high(src[18]),
    .wrn_flow_low(src[19]), .wrn_temp_high(src[20]), .wrn_act_high(src[21]),
    .wrn_act_low(src[22]), .s1_reading_valid(src[23]), .s4_reading_valid(src[24]),
    .s5_reading_valid(src[25]), .rd_req(rd_req), .rd_group(rd_group),
    .rd_index(rd_index), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .exc_status(exc_status));

  edsb_master edsb_master_inst (.clock(clock), .rd_req(rd_req), .rd_group(rd_group),
    .rd_index(rd_index), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data));

  // Expected byte; index 0 is the size byte
  function automatic logic [7:0] exp_byte(input int g, input int i, input logic [25:0] s);
    case (6'(g * 8 + i))
      6'h00, 6'h18: return 8'h02;
      6'h08, 6'h20: return 8'h05;
      6'h10, 6'h28: return 8'h01;
      6'h01: return {3'h0, s[0], s[1], s[2], 1'b0, s[3]};
      6'h09: return {4'h0, s[4], s[5], s[6], 1'b0};
      6'h0A: return {s[7], 1'b0, s[8], s[9], 4'h0};
      6'h0B: return {7'h00, s[10]};
      6'h11: return {6'h00, s[11], s[12]};
      6'h19: return {7'h00, s[13]};
      6'h21: return {4'h0, s[14], s[15], s[16], ~s[23]};
      6'h22: return {s[17], ~s[25], s[18], s[19], ~s[24], 3'h0};
      6'h23: return {7'h00, s[20]};
      6'h29: return {6'h00, s[21], s[22]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Drive one source pattern, then read every group at indices 0 to 6
  task automatic sweep(input logic [25:0] s, input string name);
    logic [9:0] ans, after;
    logic [9:0] want;
    logic [7:0] stat;
    logic       err;
    @(negedge clock);
    src = s;
    repeat (6) @(posedge clock);
    stat = 8'h80;
    for (int g = 0; g < 6; g++) begin
      for (int i = 1; i < 6; i++) begin
        stat[g < 3 ? g : g + 1] |= |exp_byte(g, i, s);
      end
    end
    #1;
    check({2'h0, exc_status}, {2'h0, stat}, "summary");
    for (int g = 0; g < 8; g++) begin
      for (int i = 0; i < 7; i++) begin
        err = (g > 5) || (i > exp_byte(g, 0, s));
        edsb_master_inst.read(3'(g), 3'(i), ans, after);
        want = {1'b1, err, err ? 8'h00 : exp_byte(g, i, s)};
        check(ans, want, name);
        check(after, 10'h000, "idle");
      end
    end
    $display("test %s done", name);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    sweep(26'h3800000, "quiet");
    for (int k = 0; k < 26; k++) begin
      sweep(26'h3800000 ^ (26'h0000001 << k), $sformatf("source %0d", k));
    end
    sweep(26'h07FFFFF, "all raised");
    @(negedge clock);
    arst_n = 1'b0;
    @(negedge clock);
    check({rd_ack, rd_err, exc_status}, 10'h080, "reset");
    arst_n = 1'b1;
    sweep(26'h3800000, "after reset");
    finish_test();
  end

  initial begin
    #1000000;
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test();
  end
endmodule
